// ---- design/uct_regs.sv ----
// control, address, frame and token registers of a dual-role usb block
// assumes the link engine reports token completion and received frames
//
// The register offsets and the strobed register port were left to the implementer.
`default_nettype none
module uct_regs #(
  parameter int FRAME_CYCLES = uct_pkg::FRAME_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // link engine status
  input wire logic token_done_i,
  input wire logic sof_rx_i,
  input wire logic [10:0] sof_frame_i,
  // link engine control
  output uct_pkg::uct_token_t token_o,
  output logic token_start_o,
  output logic sof_send_o,
  output logic module_en_o,
  output logic host_en_o,
  output logic host_logic_rst_o,
  output logic pp_reset_o,
  output logic resume_o,
  output logic ls_eop_o
);
  import uct_pkg::*;

  logic [7:0] ctl_q;
  logic [7:0] addr_q;
  logic [7:0] tok_q;
  logic [10:0] frame_q;
  uct_tok_state_t tk_q;
  uct_tok_state_t tk_d;
  logic [31:0] rdata_d;
  logic sof_done;
  logic eop_busy;
  logic eop_done;
  logic sof_timer_busy;

  // write decode
  wire wr_ctl = reg_we_i && (reg_addr_i == OFS_CONTROL);
  wire wr_addr = reg_we_i && (reg_addr_i == OFS_ADDRESS);
  wire wr_tok = reg_we_i && (reg_addr_i == OFS_TOKEN);
  // read decode, used by the read-back checks
  wire rd_ctl = reg_re_i && (reg_addr_i == OFS_CONTROL);
  wire rd_addr = reg_re_i && (reg_addr_i == OFS_ADDRESS);
  wire rd_flo = reg_re_i && (reg_addr_i == OFS_FRAME_LO);
  wire rd_fhi = reg_re_i && (reg_addr_i == OFS_FRAME_HI);
  wire rd_link = reg_re_i && (reg_addr_i == OFS_LINK);
  wire host = ctl_q[CTL_HOST_BIT];
  wire busy = (tk_q == TK_BUSY);
  wire pid_ok = (reg_wdata_i[7:4] == PID_SETUP) || (reg_wdata_i[7:4] == PID_IN) ||
    (reg_wdata_i[7:4] == PID_OUT);
  wire launch = wr_tok && host && pid_ok && !busy && !host_logic_rst_o;
  wire host_toggle = wr_ctl && (reg_wdata_i[CTL_HOST_BIT] != host);
  wire resume_fall = wr_ctl && host && ctl_q[CTL_RESUME_BIT] &&
    !reg_wdata_i[CTL_RESUME_BIT];
  // frame-start timer runs only in host role with bit 0 set
  wire sof_run = host && ctl_q[CTL_EN_BIT] && !host_logic_rst_o;
  // reload at first enable and at every expiry
  wire sof_start = sof_run && (!sof_timer_busy || sof_done);
  wire [7:0] ctl_rd = {2'b00, busy, ctl_q[4:0]};

  // token state: busy until the engine reports done
  always_comb begin
    tk_d = tk_q;
    unique case (tk_q)
      TK_IDLE: if (launch) tk_d = TK_BUSY;
      TK_BUSY: if (token_done_i || host_logic_rst_o) tk_d = TK_IDLE;
      default: tk_d = TK_IDLE;
    endcase
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rdata_d = 32'h0;
    unique case (reg_addr_i)
      OFS_CONTROL: rdata_d = {24'h0, ctl_rd};
      OFS_ADDRESS: rdata_d = {24'h0, addr_q};
      OFS_FRAME_LO: rdata_d = {24'h0, frame_q[7:0]};
      OFS_FRAME_HI: rdata_d = {29'h0, frame_q[10:8]};
      OFS_TOKEN: rdata_d = {24'h0, tok_q};
      OFS_LINK: rdata_d = {31'h0, eop_busy};
      default: rdata_d = 32'h0;
    endcase
  end

  // control register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctl_q <= CTL_RST;
    end else if (wr_ctl) begin
      ctl_q <= {3'b000, reg_wdata_i[4:0]};
    end
  end

  // address register, low speed at bit 7
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_q <= ADDR_RST;
    end else if (wr_addr) begin
      addr_q <= reg_wdata_i[7:0];
    end
  end

  // token register and state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tok_q <= TOK_RST;
      tk_q <= TK_IDLE;
    end else begin
      if (wr_tok && !busy) tok_q <= reg_wdata_i[7:0];
      tk_q <= tk_d;
    end
  end

  // frame number loaded on received frame-start
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      frame_q <= 11'h0;
    end else if (sof_rx_i) begin
      frame_q <= sof_frame_i;
    end
  end

  // outputs, each from a flip-flop
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0;
      token_o <= '0;
      token_start_o <= 1'b0;
      sof_send_o <= 1'b0;
      module_en_o <= 1'b0;
      host_en_o <= 1'b0;
      host_logic_rst_o <= 1'b0;
      pp_reset_o <= 1'b0;
      resume_o <= 1'b0;
      ls_eop_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_re_i ? rdata_d : 32'h0;
      token_start_o <= launch;
      // speed and address go with the token
      if (launch) begin
        token_o <= '{pid: reg_wdata_i[7:4], endpoint: reg_wdata_i[3:0],
          address: addr_q[6:0], low_speed: addr_q[ADDR_LS_BIT]};
      end
      sof_send_o <= sof_done;
      module_en_o <= !host && ctl_q[CTL_EN_BIT];
      host_en_o <= host;
      // one-cycle host logic reset on toggle
      host_logic_rst_o <= host_toggle;
      // pointer reset held while bit set
      pp_reset_o <= wr_ctl ? reg_wdata_i[CTL_PPRST_BIT] : ctl_q[CTL_PPRST_BIT];
      resume_o <= wr_ctl ? reg_wdata_i[CTL_RESUME_BIT] : ctl_q[CTL_RESUME_BIT];
      ls_eop_o <= resume_fall || (eop_busy && !eop_done);
    end
  end

  // millisecond frame-start timer; the restart costs one cycle, so count one less
  uct_pulse_timer #(
    .COUNT(FRAME_CYCLES - 1)
  ) u_sof_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(sof_run),
    .start_i(sof_start),
    .busy_o(sof_timer_busy),
    .done_o(sof_done)
  );

  // low-speed eop length timer
  uct_pulse_timer #(
    .COUNT(EOP_CYC)
  ) u_eop_timer (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .run_i(1'b1),
    .start_i(resume_fall),
    .busy_o(eop_busy),
    .done_o(eop_done)
  );

  // assertions
  // busy stays set until done
  busy_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    busy && !token_done_i && !host_logic_rst_o |=> busy)
    else $error("token busy dropped early");
  launch_busy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    launch |=> busy && token_start_o)
    else $error("token launch did not set busy");
  // toggle gives one reset pulse per toggle
  sequence rst_pulse_s;
    host_logic_rst_o ##1 (host_logic_rst_o == $past(host_toggle));
  endsequence
  host_rst_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    host_toggle |=> rst_pulse_s)
    else $error("host reset pulse missing");
  sof_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sof_send_o |-> $past(sof_run, 2))
    else $error("frame start sent while disabled");
  // module enable follows bit 0 in device role
  mod_en_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    1'b1 |=> module_en_o == (!$past(host) && $past(ctl_q[CTL_EN_BIT])))
    else $error("module enable wrong");
  frame_ld_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sof_rx_i |=> frame_q == $past(sof_frame_i))
    else $error("frame number not loaded");
  eop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    resume_fall |=> ls_eop_o ##1 ls_eop_o)
    else $error("low speed eop missing");
  speed_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    launch |=> token_o.low_speed == $past(addr_q[ADDR_LS_BIT]))
    else $error("token speed wrong");
  pp_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_ctl |=> pp_reset_o == $past(reg_wdata_i[CTL_PPRST_BIT]))
    else $error("pointer reset wrong");
  pp_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !wr_ctl |=> pp_reset_o == $past(ctl_q[CTL_PPRST_BIT]))
    else $error("pointer reset lost its bit");

  // frame-start timing checks
  // timer idle while frame-start disabled
  sof_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sof_run |=> !sof_done && !sof_timer_busy)
    else $error("frame timer ran while disabled");
  sequence sof_quiet_s;
    !sof_send_o [*8];
  endsequence
  sof_space_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    sof_send_o |=> sof_quiet_s)
    else $error("frame starts too close");

  // host logic reset checks
  // reset clears token state
  host_rst_tok_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    host_logic_rst_o |=> !busy)
    else $error("token state survived host reset");
  host_rst_sof_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    host_logic_rst_o |=> !sof_timer_busy)
    else $error("frame timer survived host reset");
  host_rst_only_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !host_toggle |=> !host_logic_rst_o)
    else $error("host reset without toggle");

  // low-speed eop checks
  // eop runs several cycles
  sequence eop_run_s;
    ls_eop_o [*8];
  endsequence
  eop_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    resume_fall |=> eop_run_s)
    else $error("low speed eop too short");
  eop_end_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    eop_done && !resume_fall |=> !ls_eop_o)
    else $error("low speed eop did not end");
  eop_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_link |=> reg_rdata_o == {31'h0, $past(eop_busy)})
    else $error("eop status read wrong");

  // register read-back checks
  // address write lands
  addr_wr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_addr |=> addr_q == $past(reg_wdata_i[7:0]))
    else $error("address write lost");
  addr_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !wr_addr |=> $stable(addr_q))
    else $error("address changed without write");
  addr_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_addr |=> reg_rdata_o == {24'h0, $past(addr_q)})
    else $error("address read wrong");
  frame_ro_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sof_rx_i |=> $stable(frame_q))
    else $error("frame number changed without frame start");
  frlo_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_flo |=> reg_rdata_o == {24'h0, $past(frame_q[7:0])})
    else $error("frame low read wrong");
  frhi_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_fhi |=> reg_rdata_o == {29'h0, $past(frame_q[10:8])})
    else $error("frame high read wrong");

  // token handshake checks
  // only defined codes launched
  pid_code_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    token_start_o |-> (token_o.pid == PID_SETUP) || (token_o.pid == PID_IN) ||
      (token_o.pid == PID_OUT))
    else $error("reserved token code launched");
  busy_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd_ctl |=> (reg_rdata_o[CTL_BUSY_BIT] == $past(busy)) && (reg_rdata_o[31:8] == 24'h0))
    else $error("busy read wrong");
  busy_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    busy && token_done_i |=> !busy)
    else $error("busy stuck after completion");
  idle_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !busy && !launch |=> !busy)
    else $error("busy without launch");
  start_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !launch |=> !token_start_o)
    else $error("token start without launch");
  tok_fields_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    launch |=> (token_o.pid == $past(reg_wdata_i[7:4])) &&
      (token_o.endpoint == $past(reg_wdata_i[3:0])) &&
      (token_o.address == $past(addr_q[6:0])))
    else $error("token fields wrong");
  tok_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_tok && busy |=> $stable(tok_q))
    else $error("token overwritten while busy");
  device_tok_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wr_tok && !host |=> !token_start_o)
    else $error("token launched in device role");
endmodule : uct_regs
`default_nettype wire

// ---- inc/uct_pkg.sv ----
// package for the usb control, token and frame register block
// assumes one 40 mhz clock and a plain address/strobe register port
`default_nettype none
package uct_pkg;
  // register byte offsets; each is four times the register index
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDRESS = 8'h04;
  localparam logic [7:0] OFS_FRAME_LO = 8'h08;
  localparam logic [7:0] OFS_FRAME_HI = 8'h0c;
  localparam logic [7:0] OFS_TOKEN = 8'h10;
  localparam logic [7:0] OFS_LINK = 8'h14;
  // usb_control field positions and the address low-speed bit
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_PPRST_BIT = 1;
  localparam int CTL_RESUME_BIT = 2;
  localparam int CTL_HOST_BIT = 3;
  localparam int CTL_BUSY_BIT = 5;
  localparam int ADDR_LS_BIT = 7;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] TOK_RST = 8'h00;
  // token type codes
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_OUT = 4'h1;
  // timing
  localparam int CLK_HZ = 40000000;
  localparam int FRAME_US = 1000;
  localparam int FRAME_CYC = CLK_HZ / 1000000 * FRAME_US;
  localparam int EOP_LS_NS = 1330;
  localparam int EOP_CYC = (EOP_LS_NS * 40 + 999) / 1000;
  // token launch carrier
  typedef struct packed {
    logic [3:0] pid;
    logic [3:0] endpoint;
    logic [6:0] address;
    logic low_speed;
  } uct_token_t;
  typedef enum logic [1:0] {
    TK_IDLE = 2'b00,
    TK_BUSY = 2'b01
  } uct_tok_state_t;
endpackage : uct_pkg
`default_nettype wire

// ---- design/uct_pulse_timer.sv ----
// counts down a fixed number of cycles and pulses at the end
// assumes start is a one-cycle pulse; restart reloads the count
`default_nettype none
module uct_pulse_timer #(
  parameter int COUNT = 40000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic run_i,
  input wire logic start_i,
  // result
  output logic busy_o,
  output logic done_o
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_q;
  // reload, count down, pulse at the bottom
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && (cnt_q == W'(1));
      if (start_i) begin
        cnt_q <= W'(COUNT);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        cnt_q <= cnt_q - W'(1);
        busy_o <= (cnt_q != W'(1));
      end
    end
  end
endmodule : uct_pulse_timer
`default_nettype wire

// ---- verif/uct_link_model.sv ----
// link engine stand-in: finishes launched tokens, delivers frame-starts
// assumes launch pulses from the register block and the bench clock
`default_nettype none
module uct_link_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // launch and bench control
  input wire logic token_start_i,
  input wire logic [7:0] delay_i,
  input wire logic sof_go_i,
  input wire logic [10:0] sof_num_i,
  // status back to the block
  output logic token_done_o,
  output logic sof_rx_o,
  output logic [10:0] sof_frame_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] left_q;
  // token finishes a programmable wait after launch
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      left_q <= 8'h00;
      token_done_o <= 1'b0;
    end else begin
      token_done_o <= (left_q == 8'h01);
      if (token_start_i) begin
        left_q <= delay_i;
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
  // frame number valid only with its pulse, scrambled otherwise
  always_ff @(posedge clk_i) begin
    sof_rx_o <= sof_go_i & ~sys_rst_i;
    sof_frame_o <= sof_go_i ? sof_num_i : ~sof_frame_o;
  end
endmodule : uct_link_model
`default_nettype wire

// ---- verif/uct_regs_tb.sv ----
// bench for the usb control, token and frame registers
// assumes the link model stands in for the protocol engine
`default_nettype none
module uct_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uct_pkg::*;
  localparam int FC = 50;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic sof_go = 1'b0;
  logic [10:0] sof_num = 11'h000;
  logic [31:0] reg_rdata_o;
  logic token_done_i, sof_rx_i, token_start_o, sof_send_o, module_en_o, host_en_o;
  logic host_logic_rst_o, pp_reset_o, resume_o, ls_eop_o;
  logic [10:0] sof_frame_i;
  uct_token_t token_o;
  int bad_count = 0, tests_run = 0, cycles = 0, n_go = 0, n_sof = 0, n_hr = 0;
  uct_regs #(.FRAME_CYCLES(FC)) uct_regs_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .token_done_i(token_done_i),
    .sof_rx_i(sof_rx_i), .sof_frame_i(sof_frame_i), .token_o(token_o),
    .token_start_o(token_start_o), .sof_send_o(sof_send_o), .module_en_o(module_en_o),
    .host_en_o(host_en_o), .host_logic_rst_o(host_logic_rst_o), .pp_reset_o(pp_reset_o),
    .resume_o(resume_o), .ls_eop_o(ls_eop_o));
  uct_link_model uct_link_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .token_start_i(token_start_o), .delay_i(8'h14), .sof_go_i(sof_go),
    .sof_num_i(sof_num), .token_done_o(token_done_i), .sof_rx_o(sof_rx_i),
    .sof_frame_o(sof_frame_i));
  // clock and pulse counters
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    n_go <= n_go + int'(token_start_o === 1'b1);
    n_sof <= n_sof + int'(sof_send_o === 1'b1);
    n_hr <= n_hr + int'(host_logic_rst_o === 1'b1);
  end
  // hang guard
  always @(posedge clk_i) begin
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 chk(what, exp, reg_rdata_o);
  endtask : rd
  task automatic t_regs();
    rd(OFS_ADDRESS, 32'h0, "addr reset"); // zero at reset
    rd(OFS_FRAME_HI, 32'h0, "frame hi reset"); // zero at reset
    wr(OFS_ADDRESS, 32'h1ff);
    rd(OFS_ADDRESS, 32'hff, "addr rw"); // eight bits kept
    wr(OFS_FRAME_LO, 32'h5a);
    rd(OFS_FRAME_LO, 32'h0, "frame lo ro"); // write ignored
    rd(8'h40, 32'h0, "unmapped"); // unmapped address reads zero
  endtask : t_regs
  task automatic t_device();
    wr(OFS_CONTROL, 32'h3);
    @(posedge clk_i);
    #1 chk("module en", 1, module_en_o); // enable follows bit
    chk("pp reset", 1, pp_reset_o); // pointer reset asserted
    repeat (FC + 5) @(posedge clk_i);
    chk("device sof", 0, n_sof); // no frame-start as device
    wr(OFS_CONTROL, 32'h0);
    chk("pp idle", 0, pp_reset_o); // pointers left alone
    wr(OFS_TOKEN, {24'h0, PID_OUT, 4'h1});
    @(posedge clk_i);
    #1 chk("device token", 0, n_go); // no launch as device
    rd(OFS_TOKEN, 32'h11, "token store"); // value kept
    @(posedge clk_i);
    sof_go <= 1'b1;
    sof_num <= 11'h5a3;
    @(posedge clk_i);
    sof_go <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(OFS_FRAME_LO, 32'ha3, "frame lo"); // low byte captured
    rd(OFS_FRAME_HI, 32'h5, "frame hi"); // upper three bits
  endtask : t_device
  task automatic t_token(input logic [3:0] pid, input logic [3:0] ep, input logic ls);
    int n;
    wr(OFS_ADDRESS, {24'h0, ls, 7'h2b});
    rd(OFS_CONTROL, 32'h08, "idle");
    n = n_go;
    wr(OFS_TOKEN, {24'h0, pid, ep});
    @(posedge clk_i);
    #1 chk("launch", n + 1, n_go); // one launch per write
    chk("token", {pid, ep, 7'h2b, ls}, token_o); // fields handed on
    rd(OFS_CONTROL, 32'h28, "busy"); // busy while executing
    wr(OFS_TOKEN, {24'h0, pid, ep});
    @(posedge clk_i);
    #1 chk("refused", n + 1, n_go); // no launch while busy
    repeat (30) @(posedge clk_i);
    rd(OFS_CONTROL, 32'h08, "done"); // clear after finish
  endtask : t_token
  task automatic t_host();
    int n;
    int gap;
    n = n_hr;
    wr(OFS_CONTROL, 32'h08);
    repeat (2) @(posedge clk_i);
    #1 chk("host reset", n + 1, n_hr); // toggle resets host side
    chk("host en", 1, host_en_o); // host role active
    t_token(PID_SETUP, 4'h0, 1'b0); // setup code
    t_token(PID_IN, 4'hf, 1'b1); // in code
    t_token(PID_OUT, 4'h5, 1'b0); // out code
    n = n_sof;
    wr(OFS_CONTROL, 32'h09);
    gap = 0;
    wait (sof_send_o === 1'b1);
    do begin
      @(posedge clk_i);
      #1 gap++;
    end while (sof_send_o !== 1'b1 && gap < 4 * FC);
    chk("sof period", FC, gap); // one frame period apart
    repeat (FC - 10) @(posedge clk_i);
    #1 chk("sof count", n + 2, n_sof); // one per frame period
    wr(OFS_CONTROL, 32'h0c);
    chk("resume", 1, resume_o); // resume signalling on
    // resume held for 25 frame periods, then cleared
    repeat (25 * FC) @(posedge clk_i);
    wr(OFS_CONTROL, 32'h08);
    chk("resume off", 0, resume_o); // resume signalling off
    @(posedge clk_i);
    #1 chk("ls eop", 1, ls_eop_o); // eop follows resume
    rd(OFS_LINK, 32'h1, "eop busy"); // eop status visible
    repeat (70) @(posedge clk_i);
    #1 chk("eop end", 0, ls_eop_o); // eop ends
  endtask : t_host
  // reset, then scenarios
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_device();
    t_host();
    stop_test();
  end
endmodule : uct_regs_tb
`default_nettype wire
